// ==== psai_defines.svh ====
// constants for the parallel sar converter control block
`ifndef PSAI_DEFINES_SVH
`define PSAI_DEFINES_SVH
`define PSAI_RES_W 12
`define PSAI_CONV_CLKS 16
`define PSAI_SAR_BITS 12
`define PSAI_CNT_W 5
`define PSAI_CLK_NS 25
`define PSAI_BUSY_MAX_NS 20
`define PSAI_BUSY_CYC ((`PSAI_BUSY_MAX_NS / `PSAI_CLK_NS) < 1 ? 1 : (`PSAI_BUSY_MAX_NS / `PSAI_CLK_NS))
`define PSAI_RESULT_RST 12'h000
`endif

// ==== psai_pkg.sv ====
// types for the parallel sar converter control block
package psai_pkg;
  typedef enum logic [1:0] {PSAI_IDLE, PSAI_ARM, PSAI_CONV} psai_state_e;
endpackage

// ==== psai_sar_step.sv ====
// one successive approximation step on the trial code
`timescale 1ns/10ps
`include "psai_defines.svh"
module psai_sar_step
  import psai_pkg::*;
(
  input wire logic [`PSAI_RES_W-1:0] code_in,
  input wire logic [`PSAI_CNT_W-1:0] bit_idx,
  input wire logic comp_keep,
  output logic [`PSAI_RES_W-1:0] code_out
);
  // decide current bit, set next lower
  always_comb
  begin
    code_out = code_in;
    for (int i = 0; i < `PSAI_RES_W; i++)
    begin
      if (bit_idx == 5'(`PSAI_RES_W - 1 - i))
      begin
        code_out[i] = comp_keep;
        if (i > 0)
        begin
          code_out[i-1] = 1'b1;
        end
      end
    end
  end
endmodule // psai_sar_step

// ==== psai_ctrl.sv ====
// control and host interface of the parallel sar converter
`timescale 1ns/10ps
`include "psai_defines.svh"
// How it works
// - write strobe falling edge starts conversion
// - conversion begins at next conversion_clock rise
// - one bit per clock, msb first
// - busy low within 20ns of strobe
// - busy stays low until conversion done
// - result valid when busy rises
// - result is unsigned straight binary
// - bus driven only when cs and rd low
// - rd rise with addr low high powers down
// - power-down stops analog and digital circuitry
// - rd rise with addr low low wakes
// - sixteen conversion clocks per conversion
module psai_ctrl
  import psai_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic channel_addr_low,
  input wire logic channel_addr_high,
  input wire logic conversion_clock,
  input wire logic comp_out,
  output logic busy_n,
  output logic [1:0] chan_sel,
  output logic sample_en,
  output logic [`PSAI_RES_W-1:0] capacitive_dac_array,
  output logic power_down,
  output logic [`PSAI_RES_W-1:0] data_out,
  output logic [`PSAI_RES_W-1:0] data_oe
);
  typedef struct packed {
    psai_state_e st;
    logic wr_d;
    logic rd_d;
    logic clk_d;
    logic busy_n;
    logic [1:0] chan;
    logic [`PSAI_CNT_W-1:0] cnt;
    logic [`PSAI_RES_W-1:0] trial;
    logic [`PSAI_RES_W-1:0] result;
    logic pd;
  } psai_state_s;

  psai_state_s cur_ff;
  psai_state_s nxt_cur;
  logic [`PSAI_RES_W-1:0] step_code;
  logic wr_fall;
  logic rd_rise;
  logic clk_rise;
  logic rd_en;
  logic start_ok;
  logic pd_gate;
  logic pd_enter;
  logic pd_wake;
  logic busy_now_n;
  logic [`PSAI_RES_W-1:0] park_code;

  psai_sar_step u_step (
    .code_in(cur_ff.trial),
    .bit_idx(cur_ff.cnt),
    .comp_keep(comp_out),
    .code_out(step_code)
  );

  assign wr_fall = cur_ff.wr_d & ~wr_n & ~cs_n;
  assign rd_rise = ~cur_ff.rd_d & rd_n;
  // conversion_clock is far slower than ref_clk,
  // so one flop of history sees every rise
  assign clk_rise = ~cur_ff.clk_d & conversion_clock;

  // start needs idle, awake, cs low
  assign start_ok = wr_fall && (cur_ff.st == PSAI_IDLE) && !cur_ff.pd && !sys_rst;
  // only an idle, not busy part obeys rd
  assign pd_gate = (cur_ff.st == PSAI_IDLE) && cur_ff.busy_n && !cs_n && rd_rise;
  // low line high on rd rise sleeps
  assign pd_enter = pd_gate && channel_addr_low;
  // low line low on rd rise wakes
  assign pd_wake = pd_gate && !channel_addr_low;

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.wr_d = wr_n;
    nxt_cur.rd_d = rd_n;
    nxt_cur.clk_d = conversion_clock;
    case (cur_ff.st)
      PSAI_IDLE:
      begin
        // start on strobe fall with cs low
        if (start_ok)
        begin
          // registered busy drops on the next ref_clk edge
          nxt_cur.busy_n = 1'b0;
          nxt_cur.chan = {channel_addr_high, channel_addr_low};
          nxt_cur.st = PSAI_ARM;
        end
      end
      PSAI_ARM:
      begin
        // wait for first conversion clock rise
        if (clk_rise)
        begin
          nxt_cur.cnt = '0;
          nxt_cur.trial = {1'b1, {(`PSAI_RES_W-1){1'b0}}};
          nxt_cur.st = PSAI_CONV;
        end
      end
      PSAI_CONV:
      begin
        if (clk_rise)
        begin
          // bits resolved in clocks 1 to 12
          if (cur_ff.cnt < 5'(`PSAI_SAR_BITS))
          begin
            nxt_cur.trial = step_code;
          end
          if (cur_ff.cnt == 5'(`PSAI_CONV_CLKS - 1))
          begin
            nxt_cur.result = cur_ff.trial;
            nxt_cur.busy_n = 1'b1;
            nxt_cur.st = PSAI_IDLE;
          end
          else
          begin
            nxt_cur.cnt = cur_ff.cnt + 5'h01;
          end
        end
      end
      default:
      begin
        nxt_cur.st = PSAI_IDLE;
      end
    endcase
    if (pd_enter)
    begin
      nxt_cur.pd = 1'b1;
    end
    // rd rise with low line low wakes
    else if (pd_wake)
    begin
      nxt_cur.pd = 1'b0;
    end
    // sar state cleared while asleep
    // so a wake never resumes a stale code
    if (cur_ff.pd)
    begin
      nxt_cur.cnt = '0;
      nxt_cur.trial = '0;
    end
    if (sys_rst)
    begin
      nxt_cur = '0;
      nxt_cur.st = PSAI_IDLE;
      nxt_cur.wr_d = 1'b1;
      nxt_cur.rd_d = 1'b1;
      nxt_cur.busy_n = 1'b1;
      nxt_cur.result = `PSAI_RESULT_RST;
    end
  end

  // one register for all state; the synchronous
  // reset is already folded into nxt_cur
  always_ff @(posedge ref_clk)
  begin
    cur_ff <= nxt_cur;
  end

  // busy falls in the start cycle itself
  // the registered copy alone would be 25ns late
  assign busy_now_n = cur_ff.busy_n & ~start_ok;
  assign busy_n = busy_now_n;
  assign chan_sel = cur_ff.chan;
  // sample while idle; held during conversion
  assign sample_en = (cur_ff.st == PSAI_IDLE) && !cur_ff.pd;
  // analog array parked when powered down
  // so no switched charge reaches the reference
  assign park_code = '0;
  assign capacitive_dac_array = cur_ff.pd ? park_code : cur_ff.trial;
  assign power_down = cur_ff.pd;
  assign data_out = cur_ff.result;
  // drive only with cs and rd low
  assign rd_en = ~cs_n & ~rd_n;
  for (genvar b = 0; b < `PSAI_RES_W; b++)
  begin : g_oe
    assign data_oe[b] = rd_en;
  end
endmodule // psai_ctrl

// ==== psai_comp_model.sv ====
// comparator model standing in for the analog side
`timescale 1ns/10ps
module psai_comp_model(
  input wire logic [11:0] dac,
  input wire logic [11:0] vin,
  output logic keep
);
  // ideal comparator, so the code settles on vin
  assign keep = dac <= vin;
endmodule // psai_comp_model

// ==== psai_ctrl_sva.sv ====
// assertions on the converter control ports
`timescale 1ns/10ps
module psai_ctrl_sva(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic channel_addr_low,
  input wire logic channel_addr_high,
  input wire logic busy_n,
  input wire logic power_down,
  input wire logic [1:0] chan_sel,
  input wire logic [11:0] data_oe,
  input wire logic [11:0] data_out,
  input wire logic [11:0] capacitive_dac_array
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_bus_enable: assert property (data_oe == {12{!cs_n && !rd_n}}) else $error("bus enable");
  a_busy_start: assert property ($fell(wr_n) && !cs_n && $past(busy_n) && !power_down
    |-> !busy_n ##1 !busy_n) else $error("start");
  a_chan_take: assert property ($fell(wr_n) && !cs_n && $past(busy_n) && !power_down
    |=> chan_sel == $past({channel_addr_high, channel_addr_low})) else $error("channel");
  a_busy_min: assert property ($fell(busy_n) |=> !busy_n [*8]) else $error("busy short");
  a_pd_enter: assert property ($rose(power_down)
    |-> $past(busy_n) && !$past(cs_n) && $past(rd_n) && $past(channel_addr_low)) else $error("pd enter");
  a_pd_wake: assert property ($fell(power_down)
    |-> !$past(cs_n) && $past(rd_n) && !$past(channel_addr_low)) else $error("wake");
  a_pd_dark: assert property (power_down |-> capacitive_dac_array == 0 && busy_n) else $error("pd dark");
  a_data_hold: assert property (busy_n && $past(busy_n) |-> $stable(data_out)) else $error("data moved");
endmodule // psai_ctrl_sva
bind psai_ctrl psai_ctrl_sva u_psai_ctrl_sva(.*);

// ==== tb_psai_ctrl.sv ====
// testbench for the converter control block
`timescale 1ns/10ps
module tb_psai_ctrl;
  logic ref_clk = 0, sys_rst = 1, cs_n = 1, wr_n = 1, rd_n = 1, channel_addr_low = 0, channel_addr_high = 0;
  logic conversion_clock = 0, comp_out, busy_n, sample_en, power_down;
  logic [1:0] chan_sel;
  logic [11:0] capacitive_dac_array, data_out, data_oe, vin = 0;
  int err_count = 0, tests_run = 0, k, n = 0;
  psai_ctrl u_psai_ctrl(.*);
  psai_comp_model u_psai_comp_model(.dac(capacitive_dac_array), .vin(vin), .keep(comp_out));
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    n <= (n + 1) % 6;
    if (n == 5) conversion_clock <= !conversion_clock;
  end
  task chk(input logic [11:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task conv(input logic [11:0] v, input logic [1:0] ch);
    @(posedge ref_clk);
    vin <= v;
    {channel_addr_high, channel_addr_low} <= ch;
    cs_n <= 0;
    wr_n <= 0;
    // one cycle low covers 25ns minimum
    @(posedge ref_clk);
    wr_n <= 1;
    @(negedge ref_clk);
    chk(busy_n, 0);
    for (k = 0; k < 800 && busy_n !== 1'b1; k++) @(negedge ref_clk);
    if (k == 800)
    begin
      err_count++;
      report_and_stop;
    end
    chk(data_out, v);
    chk(chan_sel, ch);
    @(posedge ref_clk);
    rd_n <= 0;
    @(negedge ref_clk);
    chk(data_oe, 12'hfff);
    // cs first so the rd rise cannot power down
    @(posedge ref_clk);
    cs_n <= 1;
    @(negedge ref_clk);
    chk(data_oe, 12'h000);
    @(posedge ref_clk);
    rd_n <= 1;
    $display("conversion %h done", v);
  endtask
  task rd_pulse(input logic lo);
    @(posedge ref_clk);
    channel_addr_low <= lo;
    cs_n <= 0;
    rd_n <= 0;
    @(posedge ref_clk);
    rd_n <= 1;
    repeat (2) @(negedge ref_clk);
  endtask
  task pd_cycle;
    rd_pulse(1);
    chk(power_down, 1);
    @(posedge ref_clk);
    wr_n <= 0;
    @(posedge ref_clk);
    wr_n <= 1;
    repeat (2) @(negedge ref_clk);
    chk(busy_n, 1);
    chk(sample_en, 0);
    chk(capacitive_dac_array, 12'h000);
    rd_pulse(0);
    chk(power_down, 0);
    chk(sample_en, 1);
    $display("power down cycle done");
  endtask
  task rst_mid;
    @(posedge ref_clk);
    cs_n <= 0;
    wr_n <= 0;
    @(posedge ref_clk);
    wr_n <= 1;
    sys_rst <= 1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 0;
    @(negedge ref_clk);
    chk(busy_n, 1);
    chk(data_out, 12'h000);
    chk(power_down, 0);
    $display("mid run reset done");
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 0;
    conv(12'h000, 0);
    conv(12'hfff, 1);
    conv(12'h800, 2);
    conv(12'h7ff, 3);
    pd_cycle;
    rst_mid;
    conv(12'h5a3, 1);
    report_and_stop;
  end
endmodule // tb_psai_ctrl
